// ### panel_fault_timer.sv
// fault timer: counts an uninterrupted fault, pulses on expiry
// assumes arm and fault_in are levels synchronous to sys_clk
`timescale 1ns/10ps
module panel_fault_timer #(
    parameter int CYCLES = 2_000_000
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic arm,
    input wire logic fault_in,
    output logic expired
);

    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] count_reg;

    // ==========================================================
    // healthy restarts count
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
            expired <= 1'b0;
        end else if (!arm || !fault_in) begin
            count_reg <= '0;
            expired <= 1'b0;
        end else if (count_reg == LAST) begin
            count_reg <= '0;
            expired <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
            expired <= 1'b0;
        end
    end

    // ==========================================================
    property p_clear;
        @(posedge sys_clk) disable iff (reset)
        (!arm || !fault_in) |=> (count_reg == '0 && !expired);
    endproperty
    a_clear: assert property (p_clear) else $error("fault timer not cleared");

endmodule

// ### panel_seq_pkg.sv
// constants, states and carrier types of the panel supply sequencer
// assumes one 10 MHz clock and comparator levels synchronous to it
package panel_seq_pkg;

    // ==========================================================
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SOFT_START_US = 14_000;
    localparam int RAMP_STEPS = 128;
    // longest step interval, rounded down so the ramp fits
    localparam int STEP_CYCLES = (SOFT_START_US * (CLK_HZ / 1_000_000)) / RAMP_STEPS;
    localparam int FAULT_TIMER_MS = 200;
    localparam int FAULT_CYCLES = FAULT_TIMER_MS * (CLK_HZ / 1_000);
    localparam int DIV_W = 11;

    // ==========================================================
    // soft-start codes
    localparam int CODE_W = 7;
    localparam logic [CODE_W-1:0] CODE_ZERO = 7'h00;
    localparam logic [CODE_W-1:0] CODE_FULL = 7'h7F;
    localparam int REG_COUNT = 3;
    localparam int REG_BOOST = 0;
    localparam int REG_GATE_ON = 1;
    localparam int REG_GATE_OFF = 2;

    // ==========================================================
    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CODE_BOOST = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CODE_GATE_ON = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_CODE_GATE_OFF = 4'h4;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam int CTRL_INHIBIT_BIT = 0;
    localparam int ST_DONE_BIT = 3;
    localparam int ST_SWITCH_BIT = 4;
    localparam int ST_THERMAL_BIT = 5;
    localparam int ST_FAULT_BIT = 6;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // ==========================================================
    // sequence states, gray along the startup path
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_REF_WAIT = 3'b001,
        ST_RAMP = 3'b011,
        ST_DELAY = 3'b010,
        ST_RUN = 3'b110,
        ST_FAULT = 3'b111
    } seq_state_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic lockout_ok;
        logic ref_good;
        logic [REG_COUNT-1:0] reg_low;
        logic over_temp;
        logic cap_above;
    } sense_t;

    typedef struct packed {
        logic boost_en;
        logic gate_on_en;
        logic gate_off_en;
        logic amp_out_en;
    } supply_en_t;

    typedef struct packed {
        logic timing_capacitor_charge;
        logic timing_cap_node_discharge;
        logic block_en;
        logic source_path_switch;
        logic drain_path_switch;
    } switch_ctl_t;

endpackage

// ### panel_softstart.sv
// one 7-bit soft-start counter feeding a regulator reference dac
// assumes restart and tick are one-cycle pulses from the sequencer
`timescale 1ns/10ps
module panel_softstart
    import panel_seq_pkg::*;
#(
    parameter logic RAMP_DOWN = 1'b0
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic restart,
    input wire logic tick,
    output logic [CODE_W-1:0] code,
    output logic done
);

    localparam logic [CODE_W-1:0] START = RAMP_DOWN ? CODE_FULL : CODE_ZERO;
    localparam logic [CODE_W-1:0] STOP = RAMP_DOWN ? CODE_ZERO : CODE_FULL;

    // ==========================================================
    // ramp steps, downward when RAMP_DOWN
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            code <= CODE_ZERO;
            done <= 1'b0;
        end else if (restart) begin
            code <= START;
            done <= 1'b0;
        end else if (tick && !done) begin
            if (code == STOP) begin
                done <= 1'b1;
            end else if (RAMP_DOWN) begin
                code <= code - 7'h01;
            end else begin
                code <= code + 7'h01;
            end
        end
    end

    // ==========================================================
    // one step per tick, a decrement when RAMP_DOWN
    property p_step;
        @(posedge sys_clk) disable iff (reset)
        (tick && !done && !restart && code != STOP) |=>
            (code == (RAMP_DOWN ? $past(code) - 7'h01 : $past(code) + 7'h01));
    endproperty
    a_step: assert property (p_step) else $error("soft-start step wrong");

endmodule

// ### panel_supply_sequencer.sv
// startup and protection sequencer of a display-panel supply
// assumes comparator levels and switch_select are synchronous to sys_clk
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
// Operation
// - regulators enable together once reference good
// - each regulator has its own counter
// - boost and gate-on ramp zero to full
// - gate-off ramps full down to zero
// - whole ramp takes about 14 ms
// - charge timing capacitor only when ready
// - capacitor threshold enables switch block
// - discharge timing node before startup, lockout
// - select ignored until all four conditions
// - select high: source on, drain off
// - select low: source off, drain on
// - fault timer runs while output low
// - 200 ms fault sets latch, outputs off
// - latch cleared only by supply lockout
// - no fault timing during soft-start
// - overtemperature sets latch at once
// - lockout turns everything off, amps hi-z
module panel_supply_sequencer
    import panel_seq_pkg::*;
#(
    parameter int FAULT_TIMER_CYCLES = FAULT_CYCLES,
    parameter int STEP_TICK_CYCLES = STEP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire sense_t sense,
    input wire logic switch_select,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DATA_W-1:0] bus_rdata,
    output supply_en_t supply_en,
    output switch_ctl_t switch_ctl,
    output logic [CODE_W-1:0] dac_code_boost,
    output logic [CODE_W-1:0] dac_code_gate_on,
    output logic [CODE_W-1:0] dac_code_gate_off,
    output logic fault_latched
);

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_TICK_CYCLES - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;

    seq_state_t state_reg;
    seq_state_t state_next;
    logic [DATA_W-1:0] ctrl_reg;
    logic fault_latch_reg;
    logic thermal_seen_reg;
    logic [DIV_W-1:0] div_reg;
    logic tick_reg;
    logic restart;
    logic timer_arm;
    logic timer_expired;
    logic fault_any;
    logic ramps_done;
    logic [CODE_W-1:0] code [REG_COUNT];
    logic [REG_COUNT-1:0] done;
    logic source_reg;
    logic drain_reg;
    logic [DATA_W-1:0] status;

    // regulators powered in these states
    function automatic logic regs_on(input seq_state_t s);
        return (s == ST_RAMP) || (s == ST_DELAY) || (s == ST_RUN);
    endfunction

    // steady state after the ramps
    function automatic logic steady(input seq_state_t s);
        return (s == ST_DELAY) || (s == ST_RUN);
    endfunction

    // ==========================================================
    // sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (sense.lockout_ok) begin
                    state_next = ST_REF_WAIT;
                end
            end
            ST_REF_WAIT: begin
                if (sense.ref_good && !ctrl_reg[CTRL_INHIBIT_BIT]) begin
                    state_next = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (ramps_done) begin
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (sense.cap_above) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            ST_FAULT: begin
                state_next = ST_FAULT;
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (fault_latch_reg) begin
            state_next = ST_FAULT;
        end
        if (!sense.lockout_ok) begin
            state_next = ST_OFF;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    assign restart = (state_reg != ST_RAMP) && (state_next == ST_RAMP);

    // ==========================================================
    // step divider
    // 128 steps within 14 ms
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_reg <= DIV_ZERO;
            tick_reg <= 1'b0;
        end else if (state_reg != ST_RAMP) begin
            div_reg <= DIV_ZERO;
            tick_reg <= 1'b0;
        end else if (div_reg == DIV_LAST) begin
            div_reg <= DIV_ZERO;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // ==========================================================
    // soft-start counters
    // independent counter each
    genvar gi;
    generate
        for (gi = 0; gi < REG_COUNT; gi++) begin : g_ramp
            panel_softstart #(
                .RAMP_DOWN(gi == REG_GATE_OFF)
            ) u_ramp (
                .sys_clk(sys_clk),
                .reset(reset),
                .restart(restart),
                .tick(tick_reg),
                .code(code[gi]),
                .done(done[gi])
            );
        end
    endgenerate

    assign ramps_done = &done;
    assign dac_code_boost = code[REG_BOOST];
    assign dac_code_gate_on = code[REG_GATE_ON];
    assign dac_code_gate_off = code[REG_GATE_OFF];

    // ==========================================================
    // fault timer
    // any low output counts
    assign fault_any = |sense.reg_low;
    assign timer_arm = steady(state_reg);

    panel_fault_timer #(
        .CYCLES(FAULT_TIMER_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .arm(timer_arm),
        .fault_in(fault_any),
        .expired(timer_expired)
    );

    // ==========================================================
    // fault latch, cleared by input lockout
    // lockout clears the latch
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fault_latch_reg <= 1'b0;
            thermal_seen_reg <= 1'b0;
        end else if (!sense.lockout_ok) begin
            fault_latch_reg <= 1'b0;
            thermal_seen_reg <= 1'b0;
        end else begin
            if (sense.over_temp || timer_expired) begin
                fault_latch_reg <= 1'b1;
            end
            if (sense.over_temp) begin
                thermal_seen_reg <= 1'b1;
            end
        end
    end

    assign fault_latched = fault_latch_reg;

    // ==========================================================
    // supply enables
    // four enables together
    always_comb begin
        supply_en.boost_en = regs_on(state_reg);
        supply_en.gate_on_en = regs_on(state_reg);
        supply_en.gate_off_en = regs_on(state_reg);
        supply_en.amp_out_en = regs_on(state_reg);
    end

    // ==========================================================
    // switch control
    // select ignored unless running
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            source_reg <= 1'b0;
            drain_reg <= 1'b0;
        end else if (state_reg == ST_RUN && !fault_latch_reg) begin
            source_reg <= switch_select;
            drain_reg <= !switch_select;
        end else begin
            source_reg <= 1'b0;
            drain_reg <= 1'b0;
        end
    end

    always_comb begin
        switch_ctl.timing_capacitor_charge = steady(state_reg) && !fault_latch_reg;
        switch_ctl.timing_cap_node_discharge = !(steady(state_reg) && !fault_latch_reg);
        switch_ctl.block_en = (state_reg == ST_RUN);
        switch_ctl.source_path_switch = source_reg;
        switch_ctl.drain_path_switch = drain_reg;
    end

    // ==========================================================
    // register port
    always_comb begin
        status = READ_ZERO;
        status[2:0] = state_reg;
        status[ST_DONE_BIT] = ramps_done;
        status[ST_SWITCH_BIT] = (state_reg == ST_RUN);
        status[ST_THERMAL_BIT] = thermal_seen_reg;
        status[ST_FAULT_BIT] = fault_latch_reg;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= CTRL_RESET;
        end else if (bus_wr && bus_addr == ADDR_CTRL) begin
            ctrl_reg <= bus_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bus_rdata <= READ_ZERO;
        end else if (bus_rd) begin
            case (bus_addr)
                ADDR_STATUS: bus_rdata <= status;
                ADDR_CTRL: bus_rdata <= ctrl_reg;
                ADDR_CODE_BOOST: bus_rdata <= {1'b0, code[REG_BOOST]};
                ADDR_CODE_GATE_ON: bus_rdata <= {1'b0, code[REG_GATE_ON]};
                ADDR_CODE_GATE_OFF: bus_rdata <= {1'b0, code[REG_GATE_OFF]};
                default: bus_rdata <= READ_ZERO;
            endcase
        end else begin
            bus_rdata <= READ_ZERO;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    property p_enable_together;
        (state_reg == ST_REF_WAIT && sense.lockout_ok && sense.ref_good
            && !fault_latch_reg && !ctrl_reg[CTRL_INHIBIT_BIT])
            |=> (supply_en.boost_en && supply_en.gate_on_en && supply_en.gate_off_en);
    endproperty
    a_enable_together: assert property (p_enable_together) else $error("enables not together");

    property p_charge_ready;
        switch_ctl.timing_capacitor_charge |-> (ramps_done && !fault_latch_reg);
    endproperty
    a_charge_ready: assert property (p_charge_ready) else $error("charging too early");

    property p_discharge_lockout;
        !sense.lockout_ok |=> (switch_ctl.timing_cap_node_discharge && !switch_ctl.block_en);
    endproperty
    a_discharge_lockout: assert property (p_discharge_lockout) else $error("node not discharged");

    property p_source_path;
        (switch_ctl.block_en && switch_select && !fault_latch_reg)
            |=> (switch_ctl.source_path_switch && !switch_ctl.drain_path_switch);
    endproperty
    a_source_path: assert property (p_source_path) else $error("source path wrong");

    property p_drain_path;
        (switch_ctl.block_en && !switch_select && !fault_latch_reg)
            |=> (!switch_ctl.source_path_switch && switch_ctl.drain_path_switch);
    endproperty
    a_drain_path: assert property (p_drain_path) else $error("drain path wrong");

    property p_timer_latch;
        (timer_expired && sense.lockout_ok) |=> fault_latch_reg ##1 !supply_en.boost_en;
    endproperty
    a_timer_latch: assert property (p_timer_latch) else $error("timer did not latch");

    property p_thermal;
        (sense.over_temp && sense.lockout_ok) |=> fault_latch_reg;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal did not latch");

    property p_lockout_clear;
        !sense.lockout_ok |=> (!fault_latch_reg && !supply_en.amp_out_en);
    endproperty
    a_lockout_clear: assert property (p_lockout_clear) else $error("lockout did not clear");

    property p_no_timer_in_ramp;
        (state_reg == ST_RAMP) |-> !timer_arm;
    endproperty
    a_no_timer_in_ramp: assert property (p_no_timer_in_ramp) else $error("timer armed in ramp");

    property p_latch_blocks_switch;
        fault_latch_reg |=> (!switch_ctl.block_en && !switch_ctl.source_path_switch);
    endproperty
    a_latch_blocks_switch: assert property (p_latch_blocks_switch) else $error("switch on in fault");

endmodule

// ### panel_timing_ctrl.sv
// model of the panel timing controller that owns the select line
// assumes sel_req and lag come from the bench, synchronous to sys_clk
`timescale 1ns/10ps
module panel_timing_ctrl (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sel_req,
    input wire logic [1:0] lag,
    output logic switch_select
);
    logic [1:0] wait_reg;

    // ==========================================================
    // select follows the request lag + 1 cycles later
    // controller chooses path
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wait_reg <= 2'h0;
            switch_select <= 1'b0;
        end else if (sel_req == switch_select) begin
            wait_reg <= 2'h0;
        end else if (wait_reg == lag) begin
            wait_reg <= 2'h0;
            switch_select <= sel_req;
        end else begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

// ### tb_panel_supply_sequencer.sv
// self-checking bench of the panel supply sequencer
// assumes the sequencer package and the timing controller model
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD %0t: got %h exp %h", $time, (got), (exp)); end end
module tb_panel_supply_sequencer;
    import panel_seq_pkg::*;
    localparam int FT = 20;
    localparam int ST = 20;
    localparam supply_en_t EN_ALL = 4'hF;
    localparam supply_en_t EN_NONE = 4'h0;
    localparam switch_ctl_t SW_IDLE = 5'h08;
    localparam switch_ctl_t SW_CHG = 5'h10;
    localparam switch_ctl_t SW_HI = 5'h16;
    localparam switch_ctl_t SW_LO = 5'h15;
    localparam logic [17:0] M_OUT = 18'h003FF;

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    sense_t sense = '0;
    logic switch_select;
    logic sel_req = 1'b0;
    logic [1:0] lag = 2'h0;
    logic [ADDR_W-1:0] bus_addr = 4'h0;
    logic [DATA_W-1:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [DATA_W-1:0] bus_rdata;
    supply_en_t supply_en;
    switch_ctl_t switch_ctl;
    logic [CODE_W-1:0] dac_code_boost;
    logic [CODE_W-1:0] dac_code_gate_on;
    logic [CODE_W-1:0] dac_code_gate_off;
    logic fault_latched;
    logic [17:0] obs;
    logic [35:0] exp_q[$];
    logic [35:0] e;
    logic smp = 1'b0;
    logic [31:0] seed = 32'h7E35;
    logic [CODE_W-1:0] prev = 7'h00;
    logic s;
    int gap = 0;
    int steps = 0;
    int n;
    int err_total = 0;
    int total_checks = 0;

    always #50 sys_clk = ~sys_clk;
    assign obs = {bus_rdata, supply_en, switch_ctl, fault_latched};

    panel_supply_sequencer #(
        .FAULT_TIMER_CYCLES(FT),
        .STEP_TICK_CYCLES(ST)
    ) u_panel_supply_sequencer (
        .sys_clk(sys_clk), .reset(reset), .sense(sense), .switch_select(switch_select),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .supply_en(supply_en), .switch_ctl(switch_ctl),
        .dac_code_boost(dac_code_boost), .dac_code_gate_on(dac_code_gate_on),
        .dac_code_gate_off(dac_code_gate_off), .fault_latched(fault_latched)
    );

    panel_timing_ctrl u_panel_timing_ctrl (
        .sys_clk(sys_clk), .reset(reset), .sel_req(sel_req), .lag(lag),
        .switch_select(switch_select)
    );

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    task automatic stop_test();
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================================
    // drivers: note the expectation, flag the sample cycle
    task automatic chk_out(input logic [17:0] m, input logic [17:0] v);
        exp_q.push_back({m, v});
        smp <= 1'b1;
        @(posedge sys_clk);
        smp <= 1'b0;
    endtask

    task automatic see_out(input supply_en_t en, input switch_ctl_t sw, input logic lat);
        chk_out(M_OUT, {8'h00, en, sw, lat});
    endtask

    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic see_rd(input logic [ADDR_W-1:0] a, input logic [7:0] v, input logic [7:0] m);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        chk_out({m, 10'h000}, {v & m, 10'h000});
    endtask

    // ==========================================================
    // watchers
    always @(negedge sys_clk) begin
        if (smp) begin
            e = exp_q.pop_front();
            `CHK(obs & e[35:18], e[17:0])
        end
    end

    always @(negedge sys_clk) begin
        gap++;
        if (supply_en.boost_en && !switch_ctl.timing_capacitor_charge && dac_code_boost != prev) begin
            `CHK(dac_code_gate_on, dac_code_boost)
            `CHK(dac_code_gate_off, CODE_FULL - dac_code_boost)
            `CHK(dac_code_boost, prev + 7'h01)
            if (steps > 0) `CHK(gap, ST)
            steps++;
            gap = 0;
        end
        prev = dac_code_boost;
    end

    initial begin
        repeat (10000) @(posedge sys_clk);
        err_total++;
        stop_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        see_out(EN_NONE, SW_IDLE, 1'b0);
        see_rd(ADDR_STATUS, 8'h00, 8'hFF);
        bus_write(ADDR_CTRL, 8'h01);
        see_rd(ADDR_CTRL, 8'h01, 8'hFF);
        see_rd(4'hA, 8'h00, 8'hFF);
        seed = xs(seed);
        bus_write(ADDR_CODE_BOOST, seed[7:0]);
        see_rd(ADDR_CODE_BOOST, 8'h00, 8'hFF);
        sense.lockout_ok <= 1'b1;
        sense.ref_good <= 1'b1;
        sel_req <= 1'b1;
        repeat (6) @(posedge sys_clk);
        see_out(EN_NONE, SW_IDLE, 1'b0);
        see_rd(ADDR_STATUS, 8'h01, 8'hFF);
        bus_write(ADDR_CTRL, 8'h00);
        sense.reg_low <= 3'h7;
        repeat (2) @(posedge sys_clk);
        see_out(EN_ALL, SW_IDLE, 1'b0);
        `CHK({dac_code_boost, dac_code_gate_on, dac_code_gate_off}, {CODE_ZERO, CODE_ZERO, CODE_FULL})
        repeat (40) @(posedge sys_clk);
        see_out(EN_ALL, SW_IDLE, 1'b0);
        sense.reg_low <= 3'h0;
        n = 45;
        while (switch_ctl.timing_capacitor_charge !== 1'b1 && n < 8000) begin
            @(posedge sys_clk);
            n++;
        end
        see_out(EN_ALL, SW_CHG, 1'b0);
        `CHK(steps, 127)
        `CHK({dac_code_boost, dac_code_gate_off}, {CODE_FULL, CODE_ZERO})
        `CHK(n > 127 * ST && n <= 128 * ST + 5, 1'b1)
        for (int i = 0; i < 3; i++) begin
            sense.reg_low <= 3'(1 << i);
            repeat (15) @(posedge sys_clk);
            sense.reg_low <= 3'h0;
            @(posedge sys_clk);
        end
        repeat (10) @(posedge sys_clk);
        see_out(EN_ALL, SW_CHG, 1'b0);
        sense.cap_above <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            s = (i < 2) ? i[0] : seed[0];
            sel_req <= s;
            lag <= seed[2:1];
            repeat (7) @(posedge sys_clk);
            see_out(EN_ALL, s ? SW_HI : SW_LO, 1'b0);
        end
        seed = xs(seed);
        sense.reg_low <= 3'(1 << (seed % 3));
        repeat (16) @(posedge sys_clk);
        see_out(EN_ALL, s ? SW_HI : SW_LO, 1'b0);
        repeat (9) @(posedge sys_clk);
        see_out(EN_NONE, SW_IDLE, 1'b1);
        sense.reg_low <= 3'h0;
        sel_req <= !s;
        repeat (6) @(posedge sys_clk);
        see_out(EN_NONE, SW_IDLE, 1'b1);
        see_rd(ADDR_STATUS, 8'h47, 8'hF7);
        sense.lockout_ok <= 1'b0;
        repeat (3) @(posedge sys_clk);
        see_out(EN_NONE, SW_IDLE, 1'b0);
        sense.lockout_ok <= 1'b1;
        sense.ref_good <= 1'b0;
        repeat (3) @(posedge sys_clk);
        sense.over_temp <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sense.over_temp <= 1'b0;
        sense.ref_good <= 1'b1;
        repeat (4) @(posedge sys_clk);
        see_out(EN_NONE, SW_IDLE, 1'b1);
        see_rd(ADDR_STATUS, 8'h67, 8'hF7);
        stop_test();
    end
endmodule
